// ==== include/ext_irq_pkg.sv ====
// Package for the external interrupt sense and vector select block.
// Assumes a single 50 MHz system clock and an 8-bit register port.
package ext_irq_pkg;
  // Register offsets; the high sense register offset is the printed one.
  localparam logic [7:0] ADDR_SENSE_HIGH = 8'h3a;
  localparam logic [7:0] ADDR_MASK = 8'h39;
  localparam logic [7:0] ADDR_FLAG = 8'h38;
  localparam logic [7:0] ADDR_SENSE_LOW = 8'h3b;
  localparam logic [7:0] ADDR_MCU_CTRL = 8'h3c;
  localparam logic [7:0] ADDR_STATUS = 8'h3d;
  // Reset values.
  localparam logic [7:0] RST_SENSE_HIGH = 8'h00;
  localparam logic [7:0] RST_SENSE_LOW = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_FLAG = 8'h00;
  // Pin samples start at the idle high level, so no edge is seen as reset lets go.
  localparam logic [7:0] RST_PIN_SAMPLE = 8'hff;
  // Control register bit positions.
  localparam int BIT_UNLOCK = 0;
  localparam int BIT_SELECT = 1;
  // Unlock window in cycles.
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // Minimum asynchronous pulse width and its cycle count (rounded up).
  localparam int MIN_PULSE_NS = 50;
  localparam int CLK_PERIOD_NS = 20;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Sense codes.
  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_ANY = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } sense_t;
  // Unlock sequence states.
  typedef enum logic [1:0] {
    LOCK_IDLE = 2'b00,
    LOCK_OPEN = 2'b01,
    LOCK_TAIL = 2'b10
  } lock_state_t;
endpackage

// ==== logic/ext_irq_sense.sv ====
// External interrupt sensing for eight pins and the protected vector select.
// Assumes pins are asynchronous, the core supplies its status flag and execution region.
//
// Function
// - Select bit zero puts vectors at flash start, one at boot section base.
// - Interrupts blocked from unlock until after next instruction, or four cycles.
// - Hardware clears unlock bit four cycles after set or when select written.
// - Boot lock bits block interrupts while executing in the other section.
// - Pin activity triggers interrupts even when the pin is an output.
// - Request needs global interrupt flag and the pin's mask bit set.
// - Low level and all edges are sampled on the system clock; none work without it.
// - Wake level sampled twice by watchdog clock; vanished level gives no interrupt.
// - Low pins: 00 low, 01 reserved, 10 falling, 11 rising edge.
// - Low-pin edge pulses wider than 50 ns are caught.
// - Low level keeps requesting while the pin stays low.
// - High pins: 00 low, 01 any change, 10 falling, 11 rising.
// - High pins sampled first; pulses above two clocks are caught.
// - Low sense register resets to low-level sensing; hidden in legacy mode.
// - Flag sets on edge, clears on service or write of one, zero in level mode.
// - Mask bit one with global flag set enables the pin.
`timescale 1ns/1ps
`default_nettype none
module ext_irq_sense (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Pins and core context.
  input wire logic [7:0] ext_irq_pins,
  input wire logic global_irq_flag,
  input wire logic [7:0] irq_ack,
  input wire logic instr_done,
  input wire logic in_boot_code,
  input wire logic app_side_boot_lock,
  input wire logic boot_side_boot_lock,
  input wire logic legacy_mode,
  input wire logic wake_level_ok,
  // Outputs to the core.
  output logic [7:0] irq_request,
  output logic vectors_in_boot,
  output logic irq_suppress
);
  import ext_irq_pkg::*;

  // Three-stage synchroniser; first stage feeds only the second.
  // The first stage may go metastable, so nothing but the second stage reads it.
  // Stages two and three are compared, which filters out a single noisy sample.
  // The price is three cycles of latency between a pin change and its effect.
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] prev;
  logic [7:0] sense_low;
  logic [7:0] sense_high;
  logic [7:0] mask;
  logic [7:0] flag;
  logic select;
  logic unlock;
  logic [2:0] unlock_cnt;
  logic tail;
  lock_state_t lock_state;
  lock_state_t next_lock_state;

  // Sense code of pin n from the two sense registers.
  // Pins zero to three use the low register, pins four to seven the high one.
  // Both the edge decoder and the level decoder need it, hence one function.
  function automatic sense_t sense_of(input logic [7:0] lo, input logic [7:0] hi,
                                      input int n);
    logic [1:0] code;
    code = (n < 4) ? lo[2*n +: 2] : hi[2*(n-4) +: 2];
    return sense_t'(code);
  endfunction

  // A pin level counts once stages two and three agree.
  // While they disagree the pin is in motion and no level or edge is taken.
  // This keeps one glitchy sample from setting a flag on its own.
  wire [7:0] agreed = sync2 & sync3 | ~(sync2 ^ sync3) & sync3;
  wire [7:0] stable = ~(sync2 ^ sync3);

  // Pins are read regardless of direction, so output pins still trigger.
  // Software can therefore raise an interrupt by driving its own pin.
  // The reserved code on the low pins decodes to nothing at all.
  logic [7:0] edge_hit;
  logic [7:0] level_low;
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      level_low[n] = stable[n] & ~agreed[n] & (sense_of(sense_low, sense_high, n) == SENSE_LOW);
      case (sense_of(sense_low, sense_high, n))
        SENSE_FALL: edge_hit[n] = stable[n] & prev[n] & ~agreed[n];
        SENSE_RISE: edge_hit[n] = stable[n] & ~prev[n] & agreed[n];
        SENSE_ANY: edge_hit[n] = (n >= 4) & stable[n] & (prev[n] ^ agreed[n]);
        default: edge_hit[n] = 1'b0;
      endcase
    end
  end

  // Pin sampling; low pins are sampled here too, so pulses over MIN_PULSE_CYC edges register.
  // Sampling the low pins on the system clock is a limitation: they cannot wake a halted clock.
  // The samples reset to the idle high level so that no false edge follows reset.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= RST_PIN_SAMPLE;
      sync2 <= RST_PIN_SAMPLE;
      sync3 <= RST_PIN_SAMPLE;
      prev <= 8'hff;
    end else begin
      sync1 <= ext_irq_pins;
      sync2 <= sync1;
      sync3 <= sync2;
      prev <= stable & agreed | ~stable & prev;
    end
  end

  // Register write decode.
  // A select write is only recognised while the unlock window is open.
  // Writing the unlock bit again inside the window keeps the select bit unchanged.
  wire wr_sense_low = reg_write & (reg_addr == ADDR_SENSE_LOW) & ~legacy_mode;
  wire wr_sense_high = reg_write & (reg_addr == ADDR_SENSE_HIGH);
  wire wr_mask = reg_write & (reg_addr == ADDR_MASK);
  wire wr_flag = reg_write & (reg_addr == ADDR_FLAG);
  wire wr_ctrl = reg_write & (reg_addr == ADDR_MCU_CTRL);
  wire wr_unlock = wr_ctrl & reg_wdata[BIT_UNLOCK];
  wire wr_select = wr_ctrl & ~reg_wdata[BIT_UNLOCK] & unlock;

  // Sense and mask registers; the low register is hidden in legacy mode.
  // Changing a sense code while the pin is unmasked may raise a spurious flag.
  // Software is expected to mask the pin first and clear its flag afterwards.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sense_low <= RST_SENSE_LOW;
      sense_high <= RST_SENSE_HIGH;
      mask <= RST_MASK;
    end else begin
      if (wr_sense_low) sense_low <= reg_wdata;
      if (wr_sense_high) sense_high <= reg_wdata;
      if (wr_mask) mask <= reg_wdata;
    end
  end

  // Flags: set wins over a clear in the same cycle; level-mode pins hold zero.
  // Letting the set win means an edge that lands beside a clear is never lost.
  // A clear comes from a write of one or from the handler acknowledge.
  // Level-mode pins request straight from the pin, so their flag stays clear.
  logic [7:0] level_mode;
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      level_mode[n] = sense_of(sense_low, sense_high, n) == SENSE_LOW;
    end
  end
  wire [7:0] flag_clr = (wr_flag ? reg_wdata : 8'h00) | irq_ack;
  wire [7:0] next_flag = (edge_hit | (flag & ~flag_clr)) & ~level_mode;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) flag <= RST_FLAG;
    else flag <= next_flag;
  end

  // Unlock sequence state machine.
  // Idle waits for the unlock write, open lasts at most four cycles, and tail
  // holds interrupts off until the instruction after the select write ends.
  // An unknown state falls back to idle, which keeps the select bit guarded.
  always_comb begin
    next_lock_state = lock_state;
    case (lock_state)
      LOCK_IDLE: if (wr_unlock) next_lock_state = LOCK_OPEN;
      LOCK_OPEN: begin
        if (wr_select) next_lock_state = LOCK_TAIL;
        else if (unlock_cnt == 3'h1) next_lock_state = LOCK_IDLE;
      end
      LOCK_TAIL: if (instr_done) next_lock_state = LOCK_IDLE;
      default: next_lock_state = LOCK_IDLE;
    endcase
  end

  // Unlock counter, select bit and state register.
  // The counter loads only from idle, so a repeated unlock cannot stretch the window.
  // The select bit changes only on a write accepted inside the open window.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_state <= LOCK_IDLE;
      unlock_cnt <= 3'h0;
      select <= 1'b0;
    end else begin
      lock_state <= next_lock_state;
      if (lock_state == LOCK_IDLE && wr_unlock) unlock_cnt <= UNLOCK_CYCLES;
      else if (unlock_cnt != 3'h0) unlock_cnt <= unlock_cnt - 3'h1;
      if (wr_select) select <= reg_wdata[BIT_SELECT];
    end
  end
  assign unlock = lock_state == LOCK_OPEN;
  assign tail = lock_state == LOCK_TAIL;

  // Region lockout: boot vectors block app code and vice versa.
  // Suppression starts in the very cycle the unlock write is taken.
  // The core's global flag is left untouched; this block only gates requests.
  // A handler in a locked section could otherwise run code it may not read.
  wire region_block = select ? (~in_boot_code & app_side_boot_lock)
                             : (in_boot_code & boot_side_boot_lock);
  wire block_all = unlock | tail | (wr_unlock & lock_state == LOCK_IDLE) | region_block;
  // A low level counts as a request only once wake sampling confirms it.
  wire [7:0] active = flag | (level_low & {8{wake_level_ok}});
  wire [7:0] next_request = active & mask & {8{global_irq_flag & ~block_all}};

  // Read data mux; unmapped addresses read zero.
  // The low sense register reads as zero while legacy mode hides it.
  // The status place shows whether interrupts are being suppressed.
  wire [7:0] rd_mux =
    (reg_addr == ADDR_SENSE_LOW && !legacy_mode) ? sense_low :
    (reg_addr == ADDR_SENSE_HIGH) ? sense_high :
    (reg_addr == ADDR_MASK) ? mask :
    (reg_addr == ADDR_FLAG) ? flag :
    (reg_addr == ADDR_MCU_CTRL) ? {6'h00, select, unlock} :
    (reg_addr == ADDR_STATUS) ? {7'h00, block_all} : 8'h00;

  // Registered outputs.
  // Every output comes from a flip-flop, so the core never sees decoder glitches.
  // Read data stand for one cycle and are zero otherwise.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      irq_request <= 8'h00;
      vectors_in_boot <= 1'b0;
      irq_suppress <= 1'b0;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 8'h00;
      irq_request <= next_request;
      vectors_in_boot <= select;
      irq_suppress <= block_all;
    end
  end

  // Assertions.
  unlock_timeout_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (lock_state == LOCK_IDLE && wr_unlock) ##1 (!wr_select)[*4] |=> !unlock)
    else $error("unlock bit outlived four cycles");
  select_guard_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $changed(select) |-> $past(unlock))
    else $error("select changed without unlock");
  flag_level_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    level_mode[0] |=> (flag[0] == 1'b0 || !$past(level_mode[0])))
    else $error("flag set in level mode");
  request_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!global_irq_flag) |=> irq_request == 8'h00)
    else $error("request without global flag");
  suppress_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    unlock |=> irq_suppress && irq_request == 8'h00)
    else $error("request during unlock");
  mask_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mask == 8'h00) |=> irq_request == 8'h00)
    else $error("request while masked");
  edge_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edge_hit[4] && !level_mode[4]) |=> flag[4])
    else $error("edge missed");
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (irq_ack[2] && !edge_hit[2]) |=> !flag[2])
    else $error("flag not cleared by service");
  region_block_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (select && !in_boot_code && app_side_boot_lock) |=> irq_request == 8'h00)
    else $error("request in locked region");
  cov_move_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    wr_unlock ##[1:4] wr_select);
  cov_timeout_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    unlock ##1 !unlock && !tail);
  cov_edge_c: cover property (@(posedge sys_clk) disable iff (!reset_n) |irq_request);

  // Further checks on the select path, the pin front end and the request gating.
  // Each watches signals that this block drives, one cycle after the cause, except reserved_code_a and any_change_a, which check the same cycle.
  // Checks are written per pin where the bench exercises that pin.

  // The vector select output follows the select bit with one cycle delay.
  select_follow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    1'b1 |=> vectors_in_boot == $past(select))
    else $error("vector select output lags select bit");
  // An accepted select write closes the unlock window at once.
  unlock_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_select |=> !unlock)
    else $error("unlock bit survived select write");
  // The unlock write itself starts suppression.
  suppress_open_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wr_unlock && lock_state == LOCK_IDLE) |=> irq_suppress)
    else $error("no suppression after unlock");
  // The tail state lasts until the instruction boundary.
  tail_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (tail && !instr_done) |=> tail)
    else $error("suppression tail ended early");
  // A confirmed low level requests while it is enabled.
  level_request_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (level_low[0] && wake_level_ok && mask[0] && global_irq_flag && !block_all)
    |=> irq_request[0])
    else $error("low level did not request");
  // Without wake confirmation and without flags nothing requests.
  wake_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!wake_level_ok && flag == 8'h00) |=> irq_request == 8'h00)
    else $error("request from unconfirmed level");
  // The reserved code on a low pin detects nothing.
  reserved_code_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (sense_low[3:2] == 2'b01) |-> !edge_hit[1])
    else $error("reserved code detected an edge");
  // Any-change mode on a high pin fires on every settled change.
  any_change_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (sense_high[1:0] == 2'b01 && stable[4] && (prev[4] ^ agreed[4])) |-> edge_hit[4])
    else $error("change missed");
  // Writes to the hidden low sense register are dropped.
  legacy_hide_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (legacy_mode && reg_write && reg_addr == ADDR_SENSE_LOW) |=> $stable(sense_low))
    else $error("hidden register written");
  // Pin samples move one stage per clock.
  sample_chain_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    1'b1 |=> sync3 == $past(sync2))
    else $error("sample chain broken");
  // Writing one to a flag clears it unless a new edge arrives.
  flag_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wr_flag && reg_wdata[4] && !edge_hit[4]) |=> !flag[4])
    else $error("flag not cleared by write");
  // A low-pin edge sets its flag.
  low_edge_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (edge_hit[1] && !level_mode[1]) |=> flag[1])
    else $error("low pin edge missed");
  // Application vectors with the boot-side lock block boot code.
  boot_lock_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!select && in_boot_code && boot_side_boot_lock) |=> irq_request == 8'h00)
    else $error("request in locked boot code");
  // The previous sample tracks the settled level.
  prev_track_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    stable[4] |=> prev[4] == $past(agreed[4]))
    else $error("previous sample not updated");

  // Coverage of a level request and of region lockout.
  cov_level_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    level_low[0] && irq_request[0]);
  cov_region_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    region_block && irq_suppress);
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the external interrupt sense and vector select block.
// Assumes the register port answers reads one cycle later and pins idle high.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ext_irq_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] ext_irq_pins = 8'hff;
  logic global_irq_flag = 1'b1;
  logic [7:0] irq_ack = 8'h00;
  logic instr_done = 1'b0;
  logic in_boot_code = 1'b0;
  logic app_side_boot_lock = 1'b0;
  logic boot_side_boot_lock = 1'b0;
  logic legacy_mode = 1'b0;
  logic wake_level_ok = 1'b1;
  logic [7:0] irq_request;
  logic vectors_in_boot;
  logic irq_suppress;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int i;

  ext_irq_sense DUT (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .ext_irq_pins(ext_irq_pins), .global_irq_flag(global_irq_flag),
    .irq_ack(irq_ack), .instr_done(instr_done), .in_boot_code(in_boot_code),
    .app_side_boot_lock(app_side_boot_lock), .boot_side_boot_lock(boot_side_boot_lock),
    .legacy_mode(legacy_mode), .wake_level_ok(wake_level_ok), .irq_request(irq_request),
    .vectors_in_boot(vectors_in_boot), .irq_suppress(irq_suppress));

  // Free-running 50 MHz clock.
  always #10 sys_clk = ~sys_clk;

  // The whole run needs well under a thousand cycles, so this ceiling only trips on a hang.
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One-cycle write; the strobe drops at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the taking edge, so sample just after it.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  task automatic pin(input int n, input logic v);
    @(posedge sys_clk);
    ext_irq_pins[n] <= v;
  endtask

  initial begin
    cyc(2);
    reset_n <= 1'b1;
    cyc(4);
    // Reset values, and an unmapped place that reads zero.
    rd(ADDR_SENSE_HIGH, RST_SENSE_HIGH);
    rd(ADDR_SENSE_LOW, RST_SENSE_LOW);
    rd(ADDR_MASK, RST_MASK);
    rd(ADDR_FLAG, RST_FLAG);
    rd(ADDR_MCU_CTRL, 8'h00);
    rd(8'h00, 8'h00);
    // A select write without the unlock step must be ignored.
    wr(ADDR_MCU_CTRL, 8'h02);
    cyc(1);
    #1 check({7'h00, vectors_in_boot}, 8'h00);
    // Unlock left alone times out and releases suppression.
    wr(ADDR_MCU_CTRL, 8'h01);
    #1 check({7'h00, irq_suppress}, 8'h01);
    cyc(5);
    rd(ADDR_MCU_CTRL, 8'h00);
    check({7'h00, irq_suppress}, 8'h00);
    // Full move to boot space; suppression holds until the next instruction ends.
    wr(ADDR_MCU_CTRL, 8'h01);
    wr(ADDR_MCU_CTRL, 8'h02);
    cyc(1);
    #1 check({7'h00, vectors_in_boot}, 8'h01);
    rd(ADDR_MCU_CTRL, 8'h02);
    check({7'h00, irq_suppress}, 8'h01);
    instr_done <= 1'b1;
    cyc(1);
    instr_done <= 1'b0;
    cyc(2);
    #1 check({7'h00, irq_suppress}, 8'h00);
    // Boot vectors with the application-side lock block application code only.
    app_side_boot_lock <= 1'b1;
    cyc(3);
    #1 check({7'h00, irq_suppress}, 8'h01);
    in_boot_code <= 1'b1;
    cyc(3);
    #1 check({7'h00, irq_suppress}, 8'h00);
    app_side_boot_lock <= 1'b0;
    // Upper pin 4 through any-change, falling and rising codes; mask before each change.
    for (i = 1; i < 4; i++) begin
      wr(ADDR_MASK, 8'h00);
      wr(ADDR_SENSE_HIGH, 8'(i));
      pin(4, (i != 3));
      cyc(5);
      wr(ADDR_FLAG, 8'hff);
      wr(ADDR_MASK, 8'h10);
      pin(4, (i == 3));
      cyc(6);
      rd(ADDR_FLAG, 8'h10);
      check(irq_request, 8'h10);
      if (i == 1) begin
        wr(ADDR_FLAG, 8'h10);
      end else begin
        irq_ack <= 8'h10;
        cyc(1);
        irq_ack <= 8'h00;
      end
      rd(ADDR_FLAG, 8'h00);
    end
    // Lower pin 1: a three-cycle low pulse in falling mode, then the reserved code.
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_SENSE_LOW, 8'h08);
    wr(ADDR_FLAG, 8'hff);
    wr(ADDR_MASK, 8'h02);
    pin(1, 1'b0);
    cyc(2);
    pin(1, 1'b1);
    cyc(6);
    rd(ADDR_FLAG, 8'h02);
    check(irq_request, 8'h02);
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_SENSE_LOW, 8'h04);
    wr(ADDR_FLAG, 8'hff);
    wr(ADDR_MASK, 8'h02);
    pin(1, 1'b0);
    cyc(2);
    pin(1, 1'b1);
    cyc(6);
    rd(ADDR_FLAG, 8'h00);
    check(irq_request, 8'h00);
    // Level mode on pin 0 requests while low and never sets the flag.
    wr(ADDR_MASK, 8'h01);
    pin(0, 1'b0);
    cyc(6);
    #1 check(irq_request, 8'h01);
    rd(ADDR_FLAG, 8'h00);
    global_irq_flag <= 1'b0;
    cyc(3);
    #1 check(irq_request, 8'h00);
    global_irq_flag <= 1'b1;
    wake_level_ok <= 1'b0;
    cyc(3);
    #1 check(irq_request, 8'h00);
    wake_level_ok <= 1'b1;
    pin(0, 1'b1);
    // Legacy mode hides the lower sense register.
    legacy_mode <= 1'b1;
    wr(ADDR_SENSE_LOW, 8'hff);
    rd(ADDR_SENSE_LOW, 8'h00);
    legacy_mode <= 1'b0;
    rd(ADDR_SENSE_LOW, 8'h04);
    finish_test();
  end
endmodule
`default_nettype wire
